/* core/link_sync.sv */
// Transmit link synchronisation: frame clocks, sync, ILAS and APB regs
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps

module link_sync
    import link_sync_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link control inputs
    input wire logic sync_n,
    input wire logic sysref,
    // Sample octets from framing
    input wire logic [7:0] sample_octet,
    // Lane octet stream to the encoder
    output logic [7:0] tx_octet,
    output logic tx_is_k,
    output logic tx_scramble,
    output logic lmfc_strobe
);

    logic [1:0] subclass_reg;
    logic ilas_en_reg, alert_en_reg, scr_en_reg;
    logic [7:0] f_m1_reg, tmo_reg;
    logic [4:0] k_m1_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg;

    link_state_t state_reg, state_next;
    logic sync_q_reg, sync_prev_reg, sysref_q_reg, sysref_prev_reg;
    logic [7:0] oct_cnt_reg, oct_cnt_next;
    logic [4:0] frame_cnt_reg, frame_cnt_next;
    logic [2:0] low_cnt_reg, low_cnt_next;
    logic [1:0] ilas_mf_reg, ilas_mf_next;
    logic [7:0] lane_cnt_reg, lane_cnt_next;
    logic armed_reg, armed_next;
    logic [7:0] tmo_cnt_reg, tmo_cnt_next;
    logic [7:0] tx_octet_reg, tx_octet_next;
    logic tx_is_k_reg, tx_is_k_next;
    logic tx_scr_reg, lmfc_reg;

    // APB decode
    wire setup = psel & ~penable;
    wire access_done = psel & penable & pready_reg;
    wire hit_ctrl = (paddr == CTRL_OFFSET);
    wire hit_link = (paddr == LINK_OFFSET);
    wire hit_status = (paddr == STATUS_OFFSET);
    wire unmapped = ~(hit_ctrl | hit_link | hit_status);
    wire wr_ctrl = access_done & pwrite & hit_ctrl;
    wire wr_link = access_done & pwrite & hit_link;

    wire [31:0] ctrl_rd = {27'h0, scr_en_reg, alert_en_reg, ilas_en_reg,
                           subclass_reg};
    wire [31:0] link_rd = {8'h0, tmo_reg, 3'h0, k_m1_reg, f_m1_reg};
    wire [31:0] status_rd = {16'h0, lane_cnt_reg, 1'b0, sync_q_reg,
                             armed_reg, state_reg};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
                         hit_link ? link_rd :
                         hit_status ? status_rd : 32'h0;

    // Frame and multiframe position
    wire sc0 = (subclass_reg == SUBCLASS_0);
    wire sc1 = (subclass_reg == SUBCLASS_1);
    wire sc2 = (subclass_reg == SUBCLASS_2);
    wire frame_start = (oct_cnt_reg == 8'h00);
    wire frame_last = (oct_cnt_reg == f_m1_reg);
    wire mf_start = frame_start && (frame_cnt_reg == 5'h00);
    wire mf_last = frame_last && (frame_cnt_reg == k_m1_reg);
    wire sync_rise = sync_q_reg & ~sync_prev_reg;
    wire sysref_rise = sysref_q_reg & ~sysref_prev_reg;

    // Clock resets; subclass 0 has no source of its own
    wire sysref_rst = sc1 && sysref_rise
                      && (!alert_en_reg || armed_reg);
    wire sync_rst = sc2 && (state_reg == ST_CGS) && sync_rise;
    wire clk_rst = sysref_rst | sync_rst;
    // Subclass 0 with ILAS restarts the multiframe marker at the frame edge
    wire mf_rst = sc0 && ilas_en_reg && (state_reg == ST_WAIT)
                  && frame_last;
    wire cgs_go = (state_reg != ST_CGS) && frame_last
                  && (low_cnt_reg == SYNC_DET_EDGES);
    wire tmo_hit = ({1'b0, tmo_cnt_reg} + 9'h001) >= {1'b0, tmo_reg};

    always_comb
    begin
        if (clk_rst || frame_last)
            oct_cnt_next = 8'h00;
        else
            oct_cnt_next = oct_cnt_reg + 8'h01;
        if (clk_rst || mf_rst || mf_last)
            frame_cnt_next = 5'h00;
        else if (frame_last)
            frame_cnt_next = frame_cnt_reg + 5'h01;
        else
            frame_cnt_next = frame_cnt_reg;
    end

    // Sync request counted in frame clock edges while held low
    assign low_cnt_next = sync_q_reg ? 3'h0
        : (frame_start && low_cnt_reg != SYNC_DET_EDGES)
        ? low_cnt_reg + 3'h1 : low_cnt_reg;

    // Alert mode arm and timeout
    always_comb
    begin
        armed_next = armed_reg;
        tmo_cnt_next = tmo_cnt_reg;
        if (!alert_en_reg || !sc1)
        begin
            armed_next = 1'b0;
            tmo_cnt_next = 8'h00;
        end
        else if (sysref_rise)
        begin
            armed_next = ~armed_reg;
            tmo_cnt_next = 8'h00;
        end
        else if (armed_reg && mf_start)
        begin
            if (tmo_hit)
                armed_next = 1'b0;
            else
                tmo_cnt_next = tmo_cnt_reg + 8'h01;
        end
    end

    // Link sequencing; a request may come in any state
    always_comb
    begin
        state_next = state_reg;
        ilas_mf_next = ilas_mf_reg;
        case (state_reg)
            ST_CGS:
            begin
                if (sync_rise)
                    state_next = sc2 ? ST_K5MF : ST_WAIT;
            end
            ST_WAIT:
            begin
                if (sc0 ? frame_last : mf_last)
                    state_next = ilas_en_reg ? ST_ILAS : ST_DATA;
                ilas_mf_next = 2'h0;
            end
            ST_K5MF:
            begin
                // Counters were zeroed on entry: this is a full multiframe
                if (mf_last)
                    state_next = ilas_en_reg ? ST_ILAS : ST_DATA;
                ilas_mf_next = 2'h0;
            end
            ST_ILAS:
            begin
                if (mf_last)
                begin
                    ilas_mf_next = ilas_mf_reg + 2'h1;
                    if (ilas_mf_reg == ILAS_MF_LAST)
                        state_next = ST_DATA;
                end
            end
            ST_DATA:
            begin
                state_next = ST_DATA;
            end
            default:
            begin
                state_next = ST_CGS;
            end
        endcase
        if (cgs_go)
            state_next = ST_CGS;
    end

    // Octet mux; state changes that alter the octet fall on frame edges so frames align
    wire in_ilas = (state_reg == ST_ILAS);
    wire is_second = (f_m1_reg == 8'h00)
                     ? (frame_cnt_reg == 5'h01 && oct_cnt_reg == 8'h00)
                     : (frame_cnt_reg == 5'h00 && oct_cnt_reg == 8'h01);
    always_comb
    begin
        tx_octet_next = K28_5;
        tx_is_k_next = 1'b1;
        lane_cnt_next = 8'h00;
        if (in_ilas || state_reg == ST_DATA)
            lane_cnt_next = lane_cnt_reg + 8'h01;
        if (in_ilas)
        begin
            if (mf_start)
                tx_octet_next = K28_0;
            else if (mf_last)
                tx_octet_next = K28_3;
            else if (ilas_mf_reg == 2'h1 && is_second)
                tx_octet_next = K28_4;
            else
            begin
                tx_octet_next = lane_cnt_reg;
                tx_is_k_next = 1'b0;
            end
        end
        else if (state_reg == ST_DATA)
        begin
            tx_octet_next = sample_octet;
            tx_is_k_next = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            subclass_reg <= SUBCLASS_RESET;
            ilas_en_reg <= ILAS_EN_RESET;
            alert_en_reg <= ALERT_EN_RESET;
            scr_en_reg <= SCR_EN_RESET;
            f_m1_reg <= F_M1_RESET;
            k_m1_reg <= K_M1_RESET;
            tmo_reg <= ALERT_TMO_RESET;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= setup;
            pslverr_reg <= setup & unmapped;
            if (setup)
                prdata_reg <= unmapped ? 32'h0 : rd_mux;
            if (wr_ctrl)
            begin
                subclass_reg <= pwdata[CTRL_SUBCLASS_LSB +: 2];
                ilas_en_reg <= pwdata[CTRL_ILAS_EN_BIT];
                alert_en_reg <= pwdata[CTRL_ALERT_EN_BIT];
                scr_en_reg <= pwdata[CTRL_SCR_EN_BIT];
            end
            if (wr_link)
            begin
                f_m1_reg <= pwdata[LINK_F_LSB +: 8];
                k_m1_reg <= pwdata[LINK_K_LSB +: 5];
                tmo_reg <= pwdata[LINK_TMO_LSB +: 8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= ST_CGS;
            sync_q_reg <= 1'b0;
            sync_prev_reg <= 1'b0;
            sysref_q_reg <= 1'b0;
            sysref_prev_reg <= 1'b0;
            oct_cnt_reg <= 8'h00;
            frame_cnt_reg <= 5'h00;
            low_cnt_reg <= 3'h0;
            ilas_mf_reg <= 2'h0;
            lane_cnt_reg <= 8'h00;
            armed_reg <= 1'b0;
            tmo_cnt_reg <= 8'h00;
            tx_octet_reg <= K28_5;
            tx_is_k_reg <= 1'b1;
            tx_scr_reg <= 1'b0;
            lmfc_reg <= 1'b0;
        end
        else
        begin
            sync_q_reg <= sync_n;
            sync_prev_reg <= sync_q_reg;
            sysref_q_reg <= sysref;
            sysref_prev_reg <= sysref_q_reg;
            state_reg <= state_next;
            oct_cnt_reg <= oct_cnt_next;
            frame_cnt_reg <= frame_cnt_next;
            low_cnt_reg <= low_cnt_next;
            ilas_mf_reg <= ilas_mf_next;
            lane_cnt_reg <= lane_cnt_next;
            armed_reg <= armed_next;
            tmo_cnt_reg <= tmo_cnt_next;
            tx_octet_reg <= tx_octet_next;
            tx_is_k_reg <= tx_is_k_next;
            // Scrambling only on sample data, never on ILAS
            tx_scr_reg <= scr_en_reg && (state_reg == ST_DATA);
            lmfc_reg <= mf_start;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign tx_octet = tx_octet_reg;
    assign tx_is_k = tx_is_k_reg;
    assign tx_scramble = tx_scr_reg;
    assign lmfc_strobe = lmfc_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_sc2_release;
        sc2 && (state_reg == ST_CGS) && sync_rise;
    endsequence
    sequence s_sc0_boundary;
        sc0 && (state_reg == ST_WAIT) && frame_last;
    endsequence

    chk_sc0_no_reset: assert property (
        sc0 |-> !clk_rst)
        else $error("subclass 0 reset its frame clocks");
    chk_sysref_clock_reset: assert property (
        sc1 && !alert_en_reg && sysref_rise
        |=> oct_cnt_reg == 8'h00 && frame_cnt_reg == 5'h00)
        else $error("sysref edge did not reset frame clocks");
    chk_alert_arm_only: assert property (
        sc1 && alert_en_reg && !armed_reg && sysref_rise
        |-> !clk_rst ##1 armed_reg)
        else $error("first sysref in alert mode did not only arm");
    chk_alert_disarm: assert property (
        sc1 && alert_en_reg && armed_reg && mf_start && tmo_hit
        && !sysref_rise |=> !armed_reg)
        else $error("alert timeout did not disarm");
    chk_sc2_clock_reset: assert property (
        s_sc2_release |=> mf_start ##0 (state_reg == ST_K5MF))
        else $error("sync release did not reset clocks in subclass 2");
    chk_sync_detect: assert property (
        cgs_go |=> (state_reg == ST_CGS) && frame_start ##1
        tx_octet_reg == K28_5 && tx_is_k_reg)
        else $error("sync request not answered with K28.5");
    chk_sc0_wait_end: assert property (
        (s_sc0_boundary and !cgs_go) |=> frame_start
        && (state_reg == (ilas_en_reg ? ST_ILAS : ST_DATA)))
        else $error("subclass 0 did not leave K28.5 at frame edge");
    chk_ilas_markers: assert property (
        in_ilas && mf_start |=> tx_octet_reg == K28_0 && tx_is_k_reg)
        else $error("ILAS multiframe did not open with K28.0");
    chk_lane_clear: assert property (
        state_reg == ST_CGS |=> lane_cnt_reg == 8'h00)
        else $error("lane counter not cleared during sync");
    chk_ilas_unscrambled: assert property (
        in_ilas |=> !tx_scr_reg)
        else $error("ILAS octet marked for scrambling");

endmodule : link_sync

/* include/link_sync_pkg.sv */
// Constants, register layout and state encoding for the link sync controller
package link_sync_pkg;

    // APB register offsets (byte addresses)
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] LINK_OFFSET = 12'h004;
    localparam logic [11:0] STATUS_OFFSET = 12'h008;

    // CTRL fields
    localparam int CTRL_SUBCLASS_LSB = 0;
    localparam int CTRL_ILAS_EN_BIT = 2;
    localparam int CTRL_ALERT_EN_BIT = 3;
    localparam int CTRL_SCR_EN_BIT = 4;
    localparam logic [1:0] SUBCLASS_RESET = 2'h0;
    localparam logic ILAS_EN_RESET = 1'b1;
    localparam logic ALERT_EN_RESET = 1'b0;
    localparam logic SCR_EN_RESET = 1'b0;

    // LINK fields: octets per frame minus one, frames per multiframe
    // minus one, alert timeout in multiframes
    localparam int LINK_F_LSB = 0;
    localparam int LINK_K_LSB = 8;
    localparam int LINK_TMO_LSB = 16;
    localparam logic [7:0] F_M1_RESET = 8'h01;
    localparam logic [4:0] K_M1_RESET = 5'h08;
    localparam logic [7:0] ALERT_TMO_RESET = 8'h04;

    // STATUS fields
    localparam int STATUS_STATE_LSB = 0;
    localparam int STATUS_ARMED_BIT = 5;
    localparam int STATUS_SYNC_BIT = 6;
    localparam int STATUS_LANE_LSB = 8;

    // Subclass codes
    localparam logic [1:0] SUBCLASS_0 = 2'h0;
    localparam logic [1:0] SUBCLASS_1 = 2'h1;
    localparam logic [1:0] SUBCLASS_2 = 2'h2;

    // Control characters as octets (K flag set alongside)
    localparam logic [7:0] K28_0 = 8'h1c;
    localparam logic [7:0] K28_3 = 8'h7c;
    localparam logic [7:0] K28_4 = 8'h9c;
    localparam logic [7:0] K28_5 = 8'hbc;

    // Frame clock edges needed to recognise a sync request
    localparam logic [2:0] SYNC_DET_EDGES = 3'h5;
    // Multiframes in the lane alignment sequence, minus one
    localparam logic [1:0] ILAS_MF_LAST = 2'h3;

    typedef enum logic [4:0] {
        ST_CGS = 5'b00001,
        ST_WAIT = 5'b00010,
        ST_K5MF = 5'b00100,
        ST_ILAS = 5'b01000,
        ST_DATA = 5'b10000
    } link_state_t;

endpackage : link_sync_pkg

/* testbench/rx_model.sv */
// Receiver model: raises sync requests and releases them
`timescale 1ns/1ps
module rx_model
    import link_sync_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench control
    input wire logic req,
    input wire logic glitch,
    input wire logic on_mf,
    // Link
    input wire logic [7:0] tx_octet,
    input wire logic tx_is_k,
    input wire logic lmfc_strobe,
    output logic sync_n
);
    logic hold_reg;
    logic [2:0] kcnt_reg;
    wire logic k5 = tx_is_k && tx_octet == K28_5;
    // Release needs four clean K28.5 in a row; in subclass 2 it also
    // waits for the transmitter's lmfc_strobe multiframe boundary
    wire logic go = kcnt_reg[2] && !req && (!on_mf || lmfc_strobe);
    // A glitch bypasses the hold so it can be shorter than a frame run
    assign sync_n = !(hold_reg || glitch);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hold_reg <= 1'b1;
            kcnt_reg <= 3'h0;
        end
        else
        begin
            hold_reg <= req || (hold_reg && !go);
            kcnt_reg <= k5 ? (kcnt_reg[2] ? kcnt_reg : kcnt_reg + 3'h1) : 3'h0;
        end
    end
endmodule : rx_model

/* testbench/tb_top.sv */
// Self-checking bench for the link sync controller
`timescale 1ns/1ps
module tb_top
    import link_sync_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, sysref, req, glitch, on_mf;
    logic pready, pslverr, sync_n, tx_is_k, tx_scramble, lmfc_strobe, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] sample_octet, tx_octet, prev_s;
    int n_errors, n_tests, n, nreq, d1, len, off;

    link_sync dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sync_n(sync_n), .sysref(sysref),
        .sample_octet(sample_octet), .tx_octet(tx_octet),
        .tx_is_k(tx_is_k), .tx_scramble(tx_scramble),
        .lmfc_strobe(lmfc_strobe));
    rx_model rx (.pclk(pclk), .presetn(presetn), .req(req),
        .glitch(glitch), .on_mf(on_mf), .tx_octet(tx_octet),
        .tx_is_k(tx_is_k), .lmfc_strobe(lmfc_strobe), .sync_n(sync_n));

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Previous sample is what the lane should carry one octet later
    always @(posedge pclk)
    begin
        prev_s <= sample_octet;
        sample_octet <= 8'($urandom);
    end

    task automatic summarize();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic to_strobe();
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (lmfc_strobe !== 1'b1 && n < 300);
        // A strobe that never comes is a failure, not a long wait
        if (n >= 300)
            n_errors++;
    endtask : to_strobe

    // SYSREF pulse at a given distance after a multiframe strobe
    task automatic pulse(input int o);
        to_strobe();
        repeat (o) @(posedge pclk);
        sysref <= 1'b1;
        repeat (2) @(posedge pclk);
        sysref <= 1'b0;
        to_strobe();
    endtask : pulse

    task automatic wait_oct(input logic [8:0] v, input logic any,
        input int lim);
        n = 0;
        while (n < lim && (any ? tx_is_k !== 1'b0
            : {tx_is_k, tx_octet} !== v))
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= lim)
            n_errors++;
    endtask : wait_oct

    task automatic resync(input logic [8:0] v, input logic any);
        req <= 1'b1;
        // Let an edge pass so req is never driven twice in one step
        @(posedge pclk);
        wait_oct({1'b1, K28_5}, 1'b0, 40);
        nreq = n;
        req <= 1'b0;
        while (sync_n !== 1'b1)
            @(posedge pclk);
        wait_oct(v, any, 60);
    endtask : resync

    function automatic logic [8:0] ilas_exp(input int i, input int l);
        int p;
        p = i % l;
        if (p == 0)
            return {1'b1, K28_0};
        if (p == l - 1)
            return {1'b1, K28_3};
        if (i / l == 1 && p == 1)
            return {1'b1, K28_4};
        return {1'b0, i[7:0]};
    endfunction : ilas_exp

    task automatic ilas_chk(input int l);
        for (int i = 0; i < 4 * l; i++)
        begin
            check(32'({tx_is_k, tx_octet}), 32'(ilas_exp(i, l)));
            check(32'(tx_scramble), 32'h0);
            @(posedge pclk);
        end
    endtask : ilas_chk

    task automatic data_chk(input int c, input logic s);
        repeat (c)
        begin
            check(32'({tx_is_k, tx_octet}), {24'h0, prev_s});
            check(32'(tx_scramble), 32'(s));
            @(posedge pclk);
        end
    endtask : data_chk

    initial
    begin
        #500000;
        n_errors++;
        summarize();
    end

    initial
    begin
        n_errors = 0;
        n_tests = 0;
        {psel, penable, pwrite, sysref, glitch, on_mf} = '0;
        paddr = '0;
        pwdata = '0;
        req = 1'b1;
        presetn = 1'b0;
        void'($urandom(32'h1c698453));
        off = 3 + int'($urandom % 8);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(32'({tx_is_k, tx_octet}), 32'h1bc);
        check(32'({tx_scramble, lmfc_strobe}), 32'h0);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        check(rd, 32'h4);
        apb(1'b0, LINK_OFFSET, 32'h0);
        check(rd, 32'h0004_0801);
        apb(1'b1, STATUS_OFFSET, '1);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        check(rd, 32'h1);
        apb(1'b1, 12'h00c, '1);
        check(32'(er), 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        check(rd, 32'h0);
        // Subclass 0, default frame sizes, scrambling on for data only
        apb(1'b1, CTRL_OFFSET, 32'h14);
        resync({1'b1, K28_0}, 1'b0);
        check(32'(n <= 10), 32'h1);
        ilas_chk(18);
        data_chk(30, 1'b1);
        glitch <= 1'b1;
        repeat (4) @(posedge pclk);
        glitch <= 1'b0;
        data_chk(40, 1'b1);
        resync({1'b1, K28_0}, 1'b0);
        check(32'(nreq >= 8 && nreq <= 24), 32'h1);
        ilas_chk(18);
        data_chk(10, 1'b1);
        apb(1'b1, CTRL_OFFSET, 32'h10);
        resync(9'h0, 1'b1);
        check(32'(n < 60), 32'h1);
        data_chk(20, 1'b1);
        // Both ends share F=4, K=5, alert timeout 3 multiframes
        apb(1'b1, LINK_OFFSET, 32'h0003_0403);
        len = 20;
        repeat (3) to_strobe();
        check(n, len);
        pulse(off);
        check(n, len - off - 2);
        apb(1'b1, CTRL_OFFSET, 32'h5);
        pulse(off);
        d1 = n;
        // Sysref acts two edges after the pin, so the strobe follows at 2
        check(d1, 2);
        pulse(off + 4);
        check(n, d1);
        resync({1'b1, K28_0}, 1'b0);
        check(32'(n <= len + 8), 32'h1);
        ilas_chk(len);
        data_chk(10, 1'b0);
        apb(1'b1, CTRL_OFFSET, 32'hd);
        pulse(off);
        check(n, len - off - 2);
        pulse(off);
        check(n, d1);
        pulse(off);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        check(32'(rd[5]), 32'h1);
        repeat (5) to_strobe();
        apb(1'b0, STATUS_OFFSET, 32'h0);
        check(32'(rd[5]), 32'h0);
        pulse(off);
        check(n, len - off - 2);
        apb(1'b1, CTRL_OFFSET, 32'h6);
        on_mf <= 1'b1;
        resync({1'b1, K28_0}, 1'b0);
        check(32'(n >= len && n <= len + 8), 32'h1);
        ilas_chk(len);
        data_chk(10, 1'b0);
        summarize();
    end
endmodule : tb_top
